// >>> design/dram_ref_pkg.sv
// constants shared by the dram refresh device model and its controller
// assumes a single 20 MHz ref_clk for both ends
package dram_ref_pkg;
  localparam int CLK_NS = 50;
  // command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DES = 4'h8;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ZQ = 4'h6;
  // field positions
  localparam int ADDR_W = 16;
  localparam int COL_W = 10;
  localparam int BL_BIT = 12;
  localparam int BANKS = 8;
  // timings in ns and derived cycles
  localparam int T_RP_NS = 14;
  localparam int T_RFC_NS = 350;
  localparam int T_REFI_NS = 7800;
  localparam int T_CKE_NS = 5000;
  localparam int T_CKSRE_NS = 10;
  localparam int T_CKSRX_NS = 10;
  localparam int T_XS_NS = 360;
  localparam int T_XSDLL_NS = 25600;
  localparam int ODT_OFF_NS = 100;
  localparam int T_RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RFC_CYC = (T_RFC_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_REFI_CYC = T_REFI_NS / CLK_NS;
  localparam int T_CKE_CYC = (T_CKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_CKSRE_CYC = (T_CKSRE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_CKSRX_CYC = (T_CKSRX_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_XS_CYC = (T_XS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_XSDLL_CYC = (T_XSDLL_NS + CLK_NS - 1) / CLK_NS;
  localparam int ODT_OFF_CYC = (ODT_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TCCD_BC4 = 4;
  localparam int TCCD_BL8 = 4;
  localparam int POSTPONE_MAX = 8;
  localparam int PULLIN_MAX = 8;
  localparam int CNT_W = 12;
  localparam int DEBT_W = 5;
  localparam int ROW_W = 16;
endpackage : dram_ref_pkg

// >>> design/dram_cmd_if.sv
// command bus between the memory controller and the dram device
// both ends run on the same ref_clk
`timescale 1ns/1ns
interface dram_cmd_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic odt;
  logic rst_n;
  logic [15:0] addr;
  logic [2:0] ba;
  logic clk_run;
  logic [7:0] wdata;
  logic wdata_ok;
  logic [7:0] rdata;
  logic rvalid;
  modport ctrl (
    output cs_n, ras_n, cas_n, we_n, cke, odt, rst_n, addr, ba, clk_run, wdata, wdata_ok,
    input rdata, rvalid
  );
  modport dev (
    input cs_n, ras_n, cas_n, we_n, cke, odt, rst_n, addr, ba, clk_run, wdata, wdata_ok,
    output rdata, rvalid
  );
endinterface : dram_cmd_if

// >>> design/dram_dev.sv
// device end: decodes commands, tracks banks, refresh and self-refresh
// assumes the controller keeps its own timing; errors only flag, never hang
`timescale 1ns/1ns
module dram_dev
  import dram_ref_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // command bus
  dram_cmd_if.dev bus,
  // user side status
  output logic [7:0] bank_open,
  output logic self_ref,
  output logic dll_on,
  output logic dll_reset,
  output logic refresh_busy,
  output logic [ROW_W-1:0] ref_row,
  output logic [COL_W-1:0] last_col,
  output logic burst_chop,
  output logic [3:0] burst_len,
  output logic wr_err
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_REF = 2'b01,
    S_SREF = 2'b10,
    S_EXIT = 2'b11
  } dstate_t;
  typedef struct packed {
    dstate_t st;
    logic [BANKS-1:0] open;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] sr_cnt;
    logic sr_done;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic chop;
    logic [3:0] blen;
    logic dll;
    logic dllrst;
    logic err;
    logic [7:0] mem0;
    logic cke_d;
  } dev_t;
  dev_t s_r, s_nxt;
  logic [3:0] cmd;
  assign cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
  assign bus.rdata = s_r.mem0;
  assign bus.rvalid = 1'b0;
  always_comb begin
    s_nxt = s_r;
    s_nxt.cke_d = bus.cke;
    s_nxt.dllrst = 1'b0;
    if (s_r.cnt != '0) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
    unique case (s_r.st)
      S_IDLE: begin
        if (!bus.cs_n && cmd == CMD_REF && !bus.cke && s_r.cke_d) begin
          s_nxt.st = S_SREF;
          s_nxt.dll = 1'b0;
          s_nxt.sr_cnt = CNT_W'(T_CKE_CYC);
          s_nxt.sr_done = 1'b0;
          s_nxt.open = '0;
        end else if (bus.cke && cmd == CMD_REF) begin
          s_nxt.st = S_REF;
          s_nxt.cnt = CNT_W'(T_RFC_CYC);
          if (s_r.open != '0) begin
            s_nxt.err = 1'b1;
          end
        end else if (bus.cke && cmd == CMD_ACT) begin
          s_nxt.open[bus.ba] = 1'b1;
        end else if (bus.cke && cmd == CMD_PRE) begin
          if (bus.addr[10]) begin
            s_nxt.open = '0;
          end else begin
            s_nxt.open[bus.ba] = 1'b0;
          end
        end else if (bus.cke && (cmd == CMD_RD || cmd == CMD_WR)) begin
          s_nxt.chop = !bus.addr[BL_BIT];
          s_nxt.blen = bus.addr[BL_BIT] ? 4'h8 : 4'h4;
          s_nxt.col = bus.addr[COL_W-1:0];
          if (cmd == CMD_WR && bus.addr[COL_W-1:0] == '0) begin
            // only the addressed word changes, even with a bad strobe
            s_nxt.mem0 = bus.wdata;
            s_nxt.err = s_r.err | !bus.wdata_ok;
          end
        end
      end
      S_REF: begin
        if (cmd != CMD_NOP && !bus.cs_n) begin
          s_nxt.err = 1'b1;
        end
        if (s_r.cnt == CNT_W'(1)) begin
          s_nxt.st = S_IDLE;
          s_nxt.row = s_r.row + 1'b1;
          s_nxt.open = '0;
        end
      end
      S_SREF: begin
        // only cke is looked at here
        if (s_r.sr_cnt != '0) begin
          s_nxt.sr_cnt = s_r.sr_cnt - 1'b1;
        end
        if (!s_r.sr_done) begin
          s_nxt.row = s_r.row + 1'b1;
          s_nxt.sr_done = 1'b1;
        end
        if (bus.cke && s_r.sr_cnt == '0) begin
          s_nxt.st = S_EXIT;
          s_nxt.cnt = CNT_W'(T_XS_CYC);
          s_nxt.dll = 1'b1;
          s_nxt.dllrst = 1'b1;
        end
      end
      S_EXIT: begin
        if (s_r.cnt == '0) begin
          s_nxt.st = S_IDLE;
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !bus.rst_n) begin
      s_r <= '0;
      s_r.dll <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bank_open <= '0;
      self_ref <= 1'b0;
      dll_on <= 1'b0;
      dll_reset <= 1'b0;
      refresh_busy <= 1'b0;
      ref_row <= '0;
      last_col <= '0;
      burst_chop <= 1'b0;
      burst_len <= '0;
      wr_err <= 1'b0;
    end else begin
      bank_open <= s_nxt.open;
      self_ref <= (s_nxt.st == S_SREF);
      dll_on <= s_nxt.dll;
      dll_reset <= s_nxt.dllrst;
      refresh_busy <= (s_nxt.st == S_REF);
      ref_row <= s_nxt.row;
      last_col <= s_nxt.col;
      burst_chop <= s_nxt.chop;
      burst_len <= s_nxt.blen;
      wr_err <= s_nxt.err;
    end
  end
endmodule : dram_dev

// >>> design/dram_ctrl.sv
// controller end: refresh scheduling with debt counter and self-refresh sequencing
// assumes the device answers per the shared command encodings
`timescale 1ns/1ns
module dram_ctrl
  import dram_ref_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // command bus
  dram_cmd_if.ctrl bus,
  // user side
  input wire logic sr_req,
  input wire logic sr_exit,
  input wire logic pull_in,
  output logic in_self_ref,
  output logic busy,
  output logic signed [DEBT_W-1:0] debt
);
  typedef enum logic [2:0] {
    C_IDLE = 3'b000,
    C_PRE = 3'b001,
    C_REF = 3'b010,
    C_ODT = 3'b011,
    C_SREF = 3'b100,
    C_XS = 3'b101,
    C_XDLL = 3'b110,
    C_ZQ = 3'b111
  } cstate_t;
  typedef struct packed {
    cstate_t st;
    logic [CNT_W-1:0] wait_c;
    logic [CNT_W-1:0] refi_c;
    logic signed [DEBT_W-1:0] debt;
    logic need_extra;
    logic [3:0] gap_n;
    logic sr_pend;
    logic [3:0] cmd;
    logic cke;
    logic odt;
    logic [15:0] addr;
    logic clk_run;
  } ctl_t;
  ctl_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.cmd = CMD_NOP;
    s_nxt.addr = '0;
    if (s_r.wait_c != '0) begin
      s_nxt.wait_c = s_r.wait_c - 1'b1;
    end
    if (sr_req) begin
      s_nxt.sr_pend = 1'b1;
    end
    // debt rises each interval outside self refresh, bounded at the top
    if (s_r.st != C_SREF) begin
      if (s_r.refi_c == '0) begin
        s_nxt.refi_c = CNT_W'(T_REFI_CYC - 1);
        if (s_r.debt < DEBT_W'(POSTPONE_MAX)) begin
          s_nxt.debt = s_r.debt + 1'b1;
        end
        // intervals since the last refresh, so pulled-in credit never stretches the gap
        if (s_r.gap_n != 4'hf) begin
          s_nxt.gap_n = s_r.gap_n + 1'b1;
        end
      end else begin
        s_nxt.refi_c = s_r.refi_c - 1'b1;
      end
    end
    unique case (s_r.st)
      C_IDLE: begin
        if (s_r.wait_c == '0) begin
          if (s_r.gap_n >= 4'(POSTPONE_MAX) ||
              s_r.debt >= DEBT_W'(POSTPONE_MAX) || (s_r.sr_pend && s_r.debt > 0) ||
              (s_r.sr_pend && s_r.need_extra) ||
              (pull_in && s_r.debt > -DEBT_W'(PULLIN_MAX))) begin
            s_nxt.st = C_PRE;
            s_nxt.cmd = CMD_PRE;
            s_nxt.addr[10] = 1'b1;
            s_nxt.wait_c = CNT_W'(T_RP_CYC);
          end else if (s_r.sr_pend) begin
            s_nxt.st = C_ODT;
            s_nxt.odt = 1'b0;
            s_nxt.cmd = CMD_PRE;
            s_nxt.addr[10] = 1'b1;
            s_nxt.wait_c = CNT_W'(ODT_OFF_CYC > T_RP_CYC ? ODT_OFF_CYC : T_RP_CYC);
          end
        end
      end
      C_PRE: begin
        if (s_r.wait_c == '0) begin
          s_nxt.st = C_REF;
          s_nxt.cmd = CMD_REF;
          s_nxt.gap_n = '0;
          s_nxt.wait_c = CNT_W'(T_RFC_CYC);
          s_nxt.need_extra = 1'b0;
          if (s_r.debt > -DEBT_W'(PULLIN_MAX)) begin
            s_nxt.debt = s_nxt.debt - 1'b1;
          end
        end
      end
      C_REF: begin
        if (s_r.wait_c == '0) begin
          s_nxt.st = C_IDLE;
        end
      end
      C_ODT: begin
        if (s_r.wait_c == '0) begin
          s_nxt.st = C_SREF;
          s_nxt.cmd = CMD_REF;
          s_nxt.gap_n = '0;
          s_nxt.cke = 1'b0;
          s_nxt.sr_pend = 1'b0;
          s_nxt.wait_c = CNT_W'(T_CKE_CYC > T_CKSRE_CYC ? T_CKE_CYC : T_CKSRE_CYC);
        end
      end
      C_SREF: begin
        s_nxt.cke = 1'b0;
        if (s_r.wait_c == '0) begin
          s_nxt.clk_run = 1'b0;
          if (sr_exit) begin
            s_nxt.clk_run = 1'b1;
            s_nxt.st = C_XS;
            s_nxt.wait_c = CNT_W'(T_CKSRX_CYC);
          end
        end
      end
      C_XS: begin
        if (s_r.wait_c == '0 && !s_r.cke) begin
          s_nxt.cke = 1'b1;
          s_nxt.wait_c = CNT_W'(T_XS_CYC);
          s_nxt.need_extra = 1'b1;
        end else if (s_r.wait_c == '0) begin
          s_nxt.st = C_XDLL;
          s_nxt.wait_c = CNT_W'(T_XSDLL_CYC - T_XS_CYC);
        end
      end
      C_XDLL: begin
        s_nxt.odt = 1'b0;
        if (s_r.wait_c == '0) begin
          s_nxt.st = C_ZQ;
          s_nxt.cmd = CMD_ZQ;
          s_nxt.wait_c = CNT_W'(T_XS_CYC);
        end
      end
      C_ZQ: begin
        if (s_r.wait_c == '0) begin
          s_nxt.st = C_IDLE;
        end
      end
      default: s_nxt.st = C_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.cmd <= CMD_NOP;
      s_r.cke <= 1'b1;
      s_r.clk_run <= 1'b1;
      s_r.refi_c <= CNT_W'(T_REFI_CYC - 1);
    end else begin
      s_r <= s_nxt;
    end
  end
  assign bus.cs_n = s_r.cmd[3];
  assign bus.ras_n = s_r.cmd[2];
  assign bus.cas_n = s_r.cmd[1];
  assign bus.we_n = s_r.cmd[0];
  assign bus.cke = s_r.cke;
  assign bus.odt = s_r.odt;
  assign bus.rst_n = !sys_rst;
  assign bus.addr = s_r.addr;
  assign bus.ba = '0;
  assign bus.clk_run = s_r.clk_run;
  assign bus.wdata = '0;
  assign bus.wdata_ok = 1'b1;
  assign in_self_ref = (s_r.st == C_SREF);
  assign busy = (s_r.st != C_IDLE);
  assign debt = s_r.debt;
endmodule : dram_ctrl

// >>> tb/dram_cmd_sva.sv
// checker of the command bus between refresh controller and device
// assumes both ends share ref_clk and sys_rst
`timescale 1ns/1ns
module dram_cmd_sva
  import dram_ref_pkg::*;
(
  // clock, reset and bus
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic odt,
  input wire logic [15:0] addr,
  input wire logic clk_run
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire idle = cs_n | (cmd == CMD_NOP);
  wire pre_all = (cmd == CMD_PRE) & addr[10];
  logic cke_r, sr_r, need_r;
  logic [10:0] gap_r, sr_cnt_r;
  logic [9:0] xs_r;
  wire ref_c = (cmd == CMD_REF) & cke;
  wire sre = (cmd == CMD_REF) & ~cke & cke_r;
  wire srx = sr_r & cke;
  // cycles since entry, since last refresh, left of the dll window
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cke_r <= 1'b1;
      sr_r <= 1'b0;
      need_r <= 1'b0;
      gap_r <= 11'h0;
      sr_cnt_r <= 11'h0;
      xs_r <= 10'h0;
    end else begin
      cke_r <= cke;
      sr_r <= sre | (sr_r & ~cke);
      need_r <= srx | (need_r & ~ref_c);
      gap_r <= (ref_c | sr_r) ? 11'h0 : gap_r + 11'((gap_r != 11'h7ff));
      sr_cnt_r <= sre ? 11'h0 : sr_cnt_r + 11'((sr_cnt_r != 11'h7ff));
      xs_r <= srx ? 10'(T_XSDLL_CYC) : xs_r - 10'((xs_r != 10'h0));
    end
  end
  sequence exit_quiet_s;
    idle [*8];
  endsequence
  ref_quiet_a: assert property (ref_c |=> idle [*6])
    else $error("command inside refresh time");
  pre_ref_a: assert property (ref_c |-> $past(pre_all, 2))
    else $error("refresh without precharge");
  odt_off_a: assert property (sre |-> !odt && !$past(odt) && !$past(odt, 2))
    else $error("termination on at entry");
  clk_hold_a: assert property (sre |=> clk_run)
    else $error("clock stopped early");
  clk_back_a: assert property (srx |-> clk_run && $past(clk_run))
    else $error("exit without stable clock");
  sr_min_a: assert property (srx |-> sr_cnt_r >= 11'(T_CKE_CYC - 1))
    else $error("self refresh too short");
  exit_nop_a: assert property (srx |-> exit_quiet_s)
    else $error("command inside exit time");
  dll_wait_a: assert property (xs_r != 10'h0 |-> !odt && (cke || sr_r || sre))
    else $error("cke or termination in dll window");
  reentry_ref_a: assert property (sre |-> !need_r)
    else $error("reentry without extra refresh");
  ref_gap_a: assert property (gap_r < 11'(9 * T_REFI_CYC))
    else $error("refresh gap too long");
endmodule : dram_cmd_sva

// >>> tb/dram_refresh_and_self_refresh_tb.sv
// bench: controller and device pair, plus a second device driven directly
// assumes one 20 MHz clock for all ends
`timescale 1ns/1ns
module dram_refresh_and_self_refresh_tb;
  import dram_ref_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sr_req = 1'b0;
  logic sr_exit = 1'b0;
  logic pull_in = 1'b0;
  logic saw_rst = 1'b0;
  logic in_self_ref, busy, sr_a, dll_a, sr_b, dll_b, dll_rst_b, rbusy_b, chop_b, err_b;
  logic signed [DEBT_W-1:0] debt;
  logic [7:0] bank_b;
  logic [ROW_W-1:0] row_b, row0;
  logic [COL_W-1:0] col_b;
  logic [3:0] len_b;
  logic [31:0] seed = 32'h6;
  logic [15:0] a;
  int err_total = 0;
  int n_checks = 0;
  dram_cmd_if bus_a ();
  dram_cmd_if bus_b ();
  dram_ctrl u_dram_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus_a), .sr_req(sr_req),
    .sr_exit(sr_exit), .pull_in(pull_in), .in_self_ref(in_self_ref), .busy(busy), .debt(debt));
  dram_dev u_dram_dev (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus_a), .bank_open(),
    .self_ref(sr_a), .dll_on(dll_a), .dll_reset(), .refresh_busy(), .ref_row(), .last_col(),
    .burst_chop(), .burst_len(), .wr_err());
  dram_dev u_dram_dev_b (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(bus_b), .bank_open(bank_b),
    .self_ref(sr_b), .dll_on(dll_b), .dll_reset(dll_rst_b), .refresh_busy(rbusy_b),
    .ref_row(row_b), .last_col(col_b), .burst_chop(chop_b), .burst_len(len_b), .wr_err(err_b));
  dram_cmd_sva u_dram_cmd_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .cs_n(bus_a.cs_n),
    .ras_n(bus_a.ras_n), .cas_n(bus_a.cas_n), .we_n(bus_a.we_n), .cke(bus_a.cke),
    .odt(bus_a.odt), .addr(bus_a.addr), .clk_run(bus_a.clk_run));
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (dll_rst_b === 1'b1) saw_rst <= 1'b1;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [3:0] exp_len(input logic a12);
    return a12 ? 4'h8 : 4'h4;
  endfunction : exp_len
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic chk(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : chk
  task automatic cmd_b(input logic [3:0] c, input logic [15:0] ad, input logic k);
    {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n} = c;
    bus_b.addr = ad;
    bus_b.cke = k;
    cyc(1);
    {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n} = CMD_NOP;
  endtask : cmd_b
  task automatic wait_a(input logic lvl);
    for (int k = 0; k < 3000 && in_self_ref !== lvl; k++) cyc(1);
  endtask : wait_a
  task automatic close_out;
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  initial begin
    #(CLK_NS * 20000);
    err_total++;
    close_out();
  end
  initial begin
    {bus_b.cs_n, bus_b.ras_n, bus_b.cas_n, bus_b.we_n} = CMD_NOP;
    // cke, odt, rst_n, clk_run, wdata_ok
    {bus_b.cke, bus_b.odt, bus_b.rst_n, bus_b.clk_run, bus_b.wdata_ok} = 5'h17;
    {bus_b.addr, bus_b.ba, bus_b.wdata} = 27'h0;
    cyc(20);
    sys_rst = 1'b0;
    seed = xs(seed);
    bus_b.ba = seed[2:0];
    cmd_b(CMD_ACT, seed[31:16], 1'b1);
    chk(bank_b[bus_b.ba] === 1'b1, "act");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      a = seed[15:0];
      a[12] = i[0];
      a[10] = 1'b0;
      bus_b.wdata = seed[23:16];
      cmd_b(i[1] ? CMD_RD : CMD_WR, a, 1'b1);
      chk(len_b === exp_len(a[12]) && chop_b === !a[12], "burst");
      chk(col_b === a[COL_W-1:0], "column");
      cyc(TCCD_BC4 - 1);
    end
    chk(err_b === 1'b0, "spurious error");
    cmd_b(CMD_PRE, 16'h0400, 1'b1);
    cyc(T_RP_CYC);
    cmd_b(CMD_REF, seed[31:16], 1'b1);
    chk(rbusy_b === 1'b1, "refresh decode");
    row0 = row_b;
    cyc(T_RFC_CYC);
    chk(rbusy_b === 1'b0 && bank_b === 8'h0, "idle after refresh");
    cmd_b(CMD_REF, row0, 1'b1);
    cyc(T_RFC_CYC);
    chk(row_b !== row0, "refresh row");
    row0 = row_b;
    cyc(ODT_OFF_CYC);
    cmd_b(CMD_REF, 16'h0, 1'b0);
    chk(sr_b === 1'b1 && dll_b === 1'b0, "entry");
    cyc(T_CKSRE_CYC);
    bus_b.clk_run = 1'b0;
    cmd_b(CMD_ACT, 16'h0, 1'b0);
    chk(bank_b === 8'h0 && sr_b === 1'b1, "input in self refresh");
    cyc(T_CKE_CYC);
    bus_b.clk_run = 1'b1;
    cyc(T_CKSRX_CYC);
    bus_b.cke = 1'b1;
    cyc(T_XS_CYC);
    chk(sr_b === 1'b0 && saw_rst === 1'b1 && row_b !== row0, "exit");
    cyc(T_XSDLL_CYC);
    chk(dll_b === 1'b1, "dll on");
    cmd_b(CMD_ACT, seed[15:0], 1'b1);
    bus_b.wdata_ok = 1'b0;
    cmd_b(CMD_WR, 16'h1000, 1'b1);
    bus_b.wdata_ok = 1'b1;
    cyc(2);
    chk(err_b === 1'b1, "bad write");
    bus_b.ba = bus_b.ba + 3'h1;
    cmd_b(CMD_ACT, 16'h0, 1'b1);
    chk(bank_b[bus_b.ba] === 1'b1, "hang");
    for (int i = 0; i < 600; i++) begin
      seed = xs(seed);
      pull_in = (i >= 300) | seed[3];
      cyc(1);
    end
    chk(debt === -5'sd8, "pull in cap");
    pull_in = 1'b0;
    cyc(12 * T_REFI_CYC);
    for (int r = 0; r < 2; r++) begin
      sr_req = 1'b1;
      cyc(1);
      sr_req = 1'b0;
      wait_a(1'b1);
      cyc(2);
      chk(sr_a === 1'b1 && dll_a === 1'b0 && debt <= 0, "ctrl entry");
      cyc(T_CKE_CYC);
      sr_exit = 1'b1;
      wait_a(1'b0);
      sr_exit = 1'b0;
      chk(in_self_ref === 1'b0, "ctrl exit");
    end
    cyc(T_XSDLL_CYC);
    chk(dll_a === 1'b1, "ctrl dll on");
    close_out();
  end
endmodule : dram_refresh_and_self_refresh_tb
